// ---- igt_pkg.sv ----
// Package: offsets, fields, encodings and timing of the interval guard
package igt_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] IGT_CTRL_OFS = 8'h00;
    localparam logic [7:0] IGT_STAT_OFS = 8'h04;

    // Field positions in guard_control_reg
    localparam int IGT_CLR_LSB = 4;
    localparam int IGT_EN_BIT = 3;
    localparam int IGT_MODE_BIT = 2;
    localparam int IGT_INT_LSB = 0;

    // Field positions in the status register
    localparam int IGT_ST_RUN_BIT = 0;
    localparam int IGT_ST_LOCK_BIT = 1;
    localparam int IGT_ST_ARM_BIT = 2;
    localparam int IGT_ST_DEEP_BIT = 3;

    // Values after reset
    localparam logic [3:0] IGT_CLR_RST = 4'h0;
    localparam logic IGT_EN_RST = 1'b0;
    localparam logic [31:0] IGT_RDATA_RST = 32'h0000_0000;

    // Two-step clear keys
    localparam logic [3:0] IGT_KEY_ARM = 4'ha;
    localparam logic [3:0] IGT_KEY_FIRE = 4'h5;

    // Operating mode
    typedef enum logic
    {
        IGT_MODE_WATCHDOG = 1'b0,
        IGT_MODE_TIMER = 1'b1
    } igt_mode_t;

    // Interval select encoding
    typedef enum logic [1:0]
    {
        IGT_INT_32768 = 2'b00,
        IGT_INT_8192 = 2'b01,
        IGT_INT_512 = 2'b10,
        IGT_INT_64 = 2'b11
    } igt_int_t;

    // Terminal counts in low-frequency periods
    localparam int IGT_CNT_W = 15;
    localparam logic [IGT_CNT_W-1:0] IGT_LAST_32768 = 15'h7fff;
    localparam logic [IGT_CNT_W-1:0] IGT_LAST_8192 = 15'h1fff;
    localparam logic [IGT_CNT_W-1:0] IGT_LAST_512 = 15'h01ff;
    localparam logic [IGT_CNT_W-1:0] IGT_LAST_64 = 15'h003f;
    localparam logic [IGT_CNT_W-1:0] IGT_CNT_ZERO = 15'h0000;

    // Clock rates and the half-period clear window, rounded down
    localparam int IGT_SYS_CLK_HZ = 20_000_000;
    localparam int IGT_LF_CLK_HZ = 32_768;
    localparam int IGT_WIN_W = 9;
    localparam int IGT_CLEAR_WIN_CYC_I = IGT_SYS_CLK_HZ / (2 * IGT_LF_CLK_HZ);
    localparam logic [IGT_WIN_W-1:0] IGT_CLEAR_WIN_CYC =
        IGT_WIN_W'(IGT_CLEAR_WIN_CYC_I);
    localparam logic [IGT_WIN_W-1:0] IGT_WIN_ZERO = 9'h000;

endpackage

// ---- igt_sync2.sv ----
// Two-stage synchroniser for slow level inputs
`timescale 1ns/100ps
module igt_sync2 import igt_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic hclk, // System clock
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic [WIDTH-1:0] d_in, // Level to synchronise
    output logic [WIDTH-1:0] q_out // Synchronised level
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // First stage is read only by the second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else if (ce)
        begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;

endmodule // igt_sync2

// ---- igt_interval_guard.sv ----
// Watchdog / interval timer with an AHB-Lite control slave
`timescale 1ns/100ps
module igt_interval_guard import igt_pkg::*;
(
    input wire logic hclk, // System clock, 20 MHz
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write strobe
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic [31:0] hrdata, // AHB read data
    output logic hresp, // AHB response, always OKAY
    input wire logic lf_clk_in, // 32.768 kHz counting clock
    input wire logic light_sleep_mode, // Light sleep active
    input wire logic deep_sleep_mode_a, // Deepest sleep mode A
    input wire logic deep_sleep_mode_b, // Deepest sleep mode B
    output logic sys_reset_req, // Watchdog reset request pulse
    output logic timer_irq_req // Interval timer interrupt pulse
);

    // Bus data phase state
    logic dp_valid_r;
    logic dp_write_r;
    logic [7:0] dp_addr_r;
    logic [31:0] hrdata_r;

    // Control state
    igt_mode_t mode_r;
    igt_mode_t mode_nxt;
    logic en_r;
    logic en_nxt;
    igt_int_t int_r;
    igt_int_t int_nxt;
    logic lock_r;
    logic lock_nxt;

    // Clear sequencing
    logic arm_r;
    logic arm_nxt;
    logic [IGT_WIN_W-1:0] win_r;
    logic [IGT_WIN_W-1:0] win_nxt;
    logic pend_r;
    logic pend_nxt;
    logic owe_r;
    logic owe_nxt;

    // Counter and outputs
    logic [IGT_CNT_W-1:0] cnt_r;
    logic [IGT_CNT_W-1:0] cnt_nxt;
    logic lf_prev_r;
    logic sys_reset_r;
    logic timer_irq_r;

    // Slow clock, synchronised then edge detected. It is sampled as data
    // so the whole block stays in one clock domain; the price is a tick
    // that lands about three system cycles after the slow edge
    wire lf_sync;

    igt_sync2 #(
        .WIDTH(1)
    ) u_lf_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d_in(lf_clk_in),
        .q_out(lf_sync)
    );

    wire lf_tick = lf_sync & ~lf_prev_r;

    // Address phase capture; zero wait states so hready is our own
    wire addr_take = hsel & hready & htrans[1];
    wire hit_ctrl = dp_addr_r == IGT_CTRL_OFS;
    wire wr_ctrl = dp_valid_r & dp_write_r & hit_ctrl;

    // Write data fields
    wire [3:0] w_clr = hwdata[IGT_CLR_LSB +: 4];
    wire w_en = hwdata[IGT_EN_BIT];
    wire w_mode_bit = hwdata[IGT_MODE_BIT];
    wire [1:0] w_int = hwdata[IGT_INT_LSB +: 2];

    // Power state
    wire deep_sleep = deep_sleep_mode_a | deep_sleep_mode_b;
    wire is_wd = mode_r == IGT_MODE_WATCHDOG;
    wire is_tm = mode_r == IGT_MODE_TIMER;

    // Counter runs only when enabled and not in deep sleep
    wire running = en_r & ~deep_sleep;

    // Mode: frozen once the watchdog has been enabled
    always_comb
    begin
        mode_nxt = mode_r;
        if (wr_ctrl && !lock_r)
            mode_nxt = igt_mode_t'(w_mode_bit);
    end

    // Lock latches on enable write in watchdog mode; only reset undoes it
    // Sleep modes leave it set, so a woken watchdog cannot be turned off
    assign lock_nxt = lock_r |
        (wr_ctrl & w_en & (mode_nxt == IGT_MODE_WATCHDOG));

    // Enable: a 0 is ignored while locked; settings survive deep sleep
    always_comb
    begin
        en_nxt = en_r;
        if (wr_ctrl)
        begin
            if (w_en)
                en_nxt = 1'b1;
            else if (!lock_r)
                en_nxt = 1'b0;
        end
    end

    // Interval select is writable in every mode
    assign int_nxt = wr_ctrl ? igt_int_t'(w_int) : int_r;

    // Key decode; keys written while disabled have no effect
    wire key_ok = wr_ctrl & en_r & ~deep_sleep;
    wire key_arm = key_ok & is_wd & (w_clr == IGT_KEY_ARM);
    wire key_fire = key_ok & is_wd & (w_clr == IGT_KEY_FIRE) & arm_r;
    wire tm_clear = key_ok & is_tm & w_clr[0];

    // Restart from zero when enable goes from 0 to 1
    wire restart = wr_ctrl & w_en & ~en_r;

    // Arm window: the second key must land within half a slow period
    // The cycle count is rounded down, but arm stays set one cycle past it, 306 cycles in all
    always_comb
    begin
        arm_nxt = arm_r;
        win_nxt = win_r;
        if (deep_sleep)
        begin
            arm_nxt = 1'b0;
            win_nxt = IGT_WIN_ZERO;
        end
        else if (key_arm)
        begin
            arm_nxt = 1'b1;
            win_nxt = IGT_CLEAR_WIN_CYC;
        end
        else if (wr_ctrl)
        begin
            // Any other key write breaks the sequence
            arm_nxt = 1'b0;
            win_nxt = IGT_WIN_ZERO;
        end
        else if (arm_r)
        begin
            if (win_r == IGT_WIN_ZERO)
                arm_nxt = 1'b0;
            else
                win_nxt = win_r - 9'h001;
        end
    end

    // A new clear request; a completed sequence is honoured whenever begun
    wire clear_req = key_fire | tm_clear | restart;

    // Pending clear is applied at the next slow tick; set beats consume
    // A clear never moves the counter between ticks, which keeps the
    // tick-to-tick spacing exact for whoever is timing the interval
    assign pend_nxt = deep_sleep ? 1'b0 :
        (clear_req | (pend_r & ~(lf_tick & running)));
    wire do_clear = pend_r | clear_req;

    // Selected last count before wrap
    logic [IGT_CNT_W-1:0] last_cnt;

    always_comb
    begin
        unique case (int_r)
            IGT_INT_32768: last_cnt = IGT_LAST_32768;
            IGT_INT_8192: last_cnt = IGT_LAST_8192;
            IGT_INT_512: last_cnt = IGT_LAST_512;
            IGT_INT_64: last_cnt = IGT_LAST_64;
        endcase
    end

    // Terminal reached on this tick, unless a clear is due
    wire at_last = cnt_r >= last_cnt;
    wire expire = lf_tick & running & ~do_clear & at_last;
    wire wd_expire = expire & is_wd & ~arm_r &
        ~light_sleep_mode;
    wire tm_expire = expire & is_tm;

    // A terminal tick that falls inside an open clear sequence is owed,
    // not fired: the reset waits to see whether the second key arrives,
    // so a sequence begun in time still saves the system
    wire owe_set = expire & is_wd & arm_r;
    assign owe_nxt = deep_sleep ? 1'b0 : (owe_set | (owe_r & arm_r));
    // Sequence closed with no clear queued: the owed reset goes out now
    wire owe_fire = owe_r & ~arm_r & ~pend_r & ~deep_sleep &
        ~light_sleep_mode;
    wire rst_fire = wd_expire | owe_fire;

    // Counter next value, changed only on slow ticks
    // Deep sleep pins the count at zero, so wake-up counts from zero
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (deep_sleep)
            cnt_nxt = IGT_CNT_ZERO;
        else if (lf_tick && running)
        begin
            if (do_clear)
                cnt_nxt = IGT_CNT_ZERO;
            else if (at_last)
                cnt_nxt = IGT_CNT_ZERO;
            else
                cnt_nxt = cnt_r + 15'h0001;
        end
    end

    // Read data; the counter has no read path
    // Data is captured in the address phase, so a read straight after a
    // control write still returns the value from before that write
    wire [31:0] ctrl_rd = {24'h000000, IGT_CLR_RST, en_r, mode_r, int_r};
    wire [31:0] stat_rd = {28'h0000000, deep_sleep, arm_r, lock_r,
        running};
    wire rd_ctrl = haddr[7:0] == IGT_CTRL_OFS;
    wire rd_stat = haddr[7:0] == IGT_STAT_OFS;
    wire [31:0] rd_mux = rd_ctrl ? ctrl_rd :
        (rd_stat ? stat_rd : IGT_RDATA_RST);
    wire [31:0] hrdata_nxt = (addr_take & ~hwrite) ? rd_mux : IGT_RDATA_RST;

    // Bus phase registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= IGT_CTRL_OFS;
            hrdata_r <= IGT_RDATA_RST;
        end
        else if (ce)
        begin
            dp_valid_r <= addr_take;
            dp_write_r <= hwrite;
            dp_addr_r <= haddr[7:0];
            hrdata_r <= hrdata_nxt;
        end
    end

    // Control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_r <= IGT_MODE_WATCHDOG;
            en_r <= IGT_EN_RST;
            int_r <= IGT_INT_32768;
            lock_r <= 1'b0;
        end
        else if (ce)
        begin
            mode_r <= mode_nxt;
            en_r <= en_nxt;
            int_r <= int_nxt;
            lock_r <= lock_nxt;
        end
    end

    // Clear sequencing registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            arm_r <= 1'b0;
            win_r <= IGT_WIN_ZERO;
            pend_r <= 1'b0;
            owe_r <= 1'b0;
        end
        else if (ce)
        begin
            arm_r <= arm_nxt;
            win_r <= win_nxt;
            pend_r <= pend_nxt;
            owe_r <= owe_nxt;
        end
    end

    // Counter and timeout outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_r <= IGT_CNT_ZERO;
            lf_prev_r <= 1'b0;
            sys_reset_r <= 1'b0;
            timer_irq_r <= 1'b0;
        end
        else if (ce)
        begin
            cnt_r <= cnt_nxt;
            lf_prev_r <= lf_sync;
            sys_reset_r <= rst_fire;
            timer_irq_r <= tm_expire;
        end
    end

    // Outputs straight from flops or tied off; zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign sys_reset_req = sys_reset_r;
    assign timer_irq_req = timer_irq_r;

endmodule // igt_interval_guard

// ---- igt_interval_guard_chk.sv ----
// Concurrent checks on the interval guard ports
`timescale 1ns/100ps
module igt_interval_guard_chk import igt_pkg::*;
(
    input wire logic hclk, // System clock
    input wire logic hresetn, // Reset, active low
    input wire logic ce, // Clock enable
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write strobe
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic hresp, // Response
    input wire logic light_sleep_mode, // Light sleep
    input wire logic deep_sleep_mode_a, // Deep sleep A
    input wire logic deep_sleep_mode_b, // Deep sleep B
    input wire logic sys_reset_req, // Reset pulse
    input wire logic timer_irq_req // Interrupt pulse
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Read address phase; its data phase is the next cycle
    sequence rd_any;
        hsel && hready && htrans[1] && !hwrite && ce;
    endsequence
    sequence rd_ctrl;
        rd_any ##0 haddr == {24'h000000, IGT_CTRL_OFS};
    endsequence
    // Held long enough to flush the registered pulse outputs
    sequence deep_held;
        (deep_sleep_mode_a || deep_sleep_mode_b) [*8];
    endsequence

    chk_ready_high: assert property (hreadyout == 1'b1)
        else $error("hreadyout low");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    chk_rdata_idle: assert property (!(hsel && hready && htrans[1]
        && !hwrite && ce) |=> hrdata == 32'h0000_0000)
        else $error("hrdata outside read data phase");
    chk_key_hidden: assert property (rd_ctrl |=> hrdata[31:4] == 28'h0)
        else $error("key or counter bits visible");
    chk_irq_pulse: assert property (timer_irq_req |=> !timer_irq_req [*8])
        else $error("interrupt pulse too long");
    chk_rst_pulse: assert property (sys_reset_req |=> !sys_reset_req [*8])
        else $error("reset pulse too long");
    chk_no_both: assert property (!(sys_reset_req && timer_irq_req))
        else $error("reset and interrupt together");
    chk_deep_quiet: assert property (deep_held |->
        !sys_reset_req && !timer_irq_req)
        else $error("event in deep sleep");
    chk_light_norst: assert property (light_sleep_mode [*8] |->
        !sys_reset_req)
        else $error("reset in light sleep");
endmodule // igt_interval_guard_chk

bind igt_interval_guard igt_interval_guard_chk chk_u (.hclk, .hresetn, .ce,
    .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
    .light_sleep_mode, .deep_sleep_mode_a, .deep_sleep_mode_b,
    .sys_reset_req, .timer_irq_req);

// ---- igt_interval_guard_tb.sv ----
// Self-checking bench for the interval guard
`timescale 1ns/100ps
module igt_interval_guard_tb import igt_pkg::*;
;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d;} igt_row_t;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, lf_clk_in;
    logic light_sleep_mode, deep_sleep_mode_a, deep_sleep_mode_b;
    logic sys_reset_req, timer_irq_req, s, t;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    int mismatches, checked, n;
    // Rows: write d, or read and expect d
    igt_row_t rows[15] = '{
        '{1'b0, 8'h00, 32'h00}, '{1'b0, 8'h04, 32'h00},
        '{1'b1, 8'h00, 32'hf7}, '{1'b0, 8'h00, 32'h07},
        '{1'b1, 8'h00, 32'h05}, '{1'b0, 8'h00, 32'h05},
        '{1'b1, 8'h00, 32'h06}, '{1'b0, 8'h00, 32'h06},
        '{1'b1, 8'h00, 32'h04}, '{1'b0, 8'h00, 32'h04},
        '{1'b1, 8'h08, 32'hff}, '{1'b0, 8'h08, 32'h00},
        '{1'b1, 8'h04, 32'h0f}, '{1'b0, 8'h04, 32'h00},
        '{1'b0, 8'h00, 32'h04}};

    igt_interval_guard dut_u (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .lf_clk_in, .light_sleep_mode,
        .deep_sleep_mode_a, .deep_sleep_mode_b, .sys_reset_req,
        .timer_irq_req);

    // System clock, 50 ns
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // Slow clock cut to 40 system cycles so timeouts fit the run
    initial
    begin
        lf_clk_in = 1'b0;
        forever
        begin
            repeat (20) @(posedge hclk);
            lf_clk_in <= ~lf_clk_in;
        end
    end

    // One AHB-Lite single transfer; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // Count edges until a pulse is seen or the limit runs out
    task automatic wait_ev(input int lim);
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (sys_reset_req !== 1'b1 && timer_irq_req !== 1'b1 && n < lim);
        s = sys_reset_req;
        t = timer_irq_req;
    endtask
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard, well beyond the 42k cycles the tests need
    initial
    begin
        repeat (60000) @(posedge hclk);
        mismatches++;
        finish_test;
    end

    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        light_sleep_mode = 1'b0;
        deep_sleep_mode_a = 1'b0;
        deep_sleep_mode_b = 1'b0;
        do_reset;
        foreach (rows[i])
        begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk(q === rows[i].d, "register row");
        end
        $display("register table done");
        bus(1'b1, 8'h00, 32'h0f);
        wait_ev(4000);
        chk(t === 1'b1 && s === 1'b0, "timer irq");
        wait_ev(4000);
        chk(t === 1'b1 && n == 2560, "irq period");
        repeat (1000) @(posedge hclk);
        bus(1'b1, 8'h00, 32'h1f);
        wait_ev(4000);
        chk(t === 1'b1 && n > 2540 && n < 2620, "timer clear");
        bus(1'b1, 8'h00, 32'h07);
        wait_ev(3000);
        chk(t === 1'b0, "timer stop");
        bus(1'b1, 8'h00, 32'h0f);
        wait_ev(4000);
        chk(t === 1'b1 && n > 2520 && n < 2620, "timer restart");
        $display("timer mode done");
        // Watchdog: lock, keyed clears, timeout, late second key
        do_reset;
        bus(1'b1, 8'h00, 32'h0b);
        bus(1'b1, 8'h00, 32'h07);
        bus(1'b0, 8'h00, 32'h0);
        chk(q === 32'h0b, "watchdog lock");
        repeat (4)
        begin
            wait_ev(1500);
            chk(s === 1'b0 && t === 1'b0, "early reset");
            bus(1'b1, 8'h00, 32'hab);
            bus(1'b1, 8'h00, 32'h5b);
        end
        wait_ev(4000);
        chk(s === 1'b1 && t === 1'b0 && n > 2540 && n < 2620, "timeout");
        wait_ev(1000);
        bus(1'b1, 8'h00, 32'hab);
        repeat (400) @(posedge hclk);
        bus(1'b1, 8'h00, 32'h5b);
        wait_ev(2000);
        chk(s === 1'b1 && n < 1300, "late key");
        // First key before the terminal tick, second after it
        repeat (2400) @(posedge hclk);
        bus(1'b1, 8'h00, 32'hab);
        wait_ev(200);
        chk(s === 1'b0 && n == 200, "reset owed");
        bus(1'b1, 8'h00, 32'h5b);
        wait_ev(2000);
        chk(s === 1'b0, "late clear honoured");
        $display("watchdog mode done");
        deep_sleep_mode_b <= 1'b1;
        wait_ev(3000);
        chk(s === 1'b0, "deep sleep quiet");
        deep_sleep_mode_b <= 1'b0;
        wait_ev(4000);
        chk(s === 1'b1 && n > 2520 && n < 2660, "count from zero");
        bus(1'b0, 8'h00, 32'h0);
        chk(q === 32'h0b, "settings kept");
        light_sleep_mode <= 1'b1;
        wait_ev(6000);
        chk(s === 1'b0, "light sleep");
        light_sleep_mode <= 1'b0;
        $display("sleep tests done");
        finish_test;
    end
endmodule // igt_interval_guard_tb
